/* File: design/ips_top.sv */
// Interrupt priority registers, request flags and AXI4-Lite access
//
// Functional notes
// - Priority A bit 7 sets the level of external line 0.
// - Priority A bit 6 sets the level of external line 1.
// - Priority A bit 5 sets one level for lines 2 and 3.
// - Priority A bit 4 sets one level for lines 4 and 5.
// - Priority A bit 3 sets watchdog and refresh request level.
// - Priority A bit 2 sets timer channel 0 level.
// - Priority A bit 1 sets timer channel 1 level.
// - Priority A bit 0 sets timer channel 2 level.
// - Priority bit 0 means low level 0, 1 means high level 1.
// - Priority B clears to zero on reset and in hardware standby.
// - Priority B bit 7 sets timer channel 3 level.
// - Priority B bit 6 sets timer channel 4 level.
// - Priority B bit 5 sets one level for both DMA channels.
// - Priority B bits 4 and 0 are plain storage, no effect.
// - Priority B bit 3 sets serial channel 0 level.
// - Priority B bit 2 sets serial channel 1 level.
// - Priority B bit 1 sets converter request level.
// - Request flags clear to zero on reset and in hardware standby.
// - Flag register bits 7 and 6 read as zero, not writable.
// - Flag sets while pin low, or on falling edge in edge mode.
// - A write clears a flag only by writing 0 after reading 1; 1 ignored.
// - Exception handling clears flag; level mode needs pin high.
// - Priority A clears to zero on reset and in hardware standby.
// - Same level: smaller source number wins.
`timescale 1ns/1ps
`include "ips_map.svh"
module ips_top (
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  input  wire logic                      hwStandby,
  input  wire logic [`IPS_NUM_LINES-1:0] externalRequestLineN,
  input  wire logic [`IPS_NUM_INT-1:0]   intRequest,
  input  wire logic                      excAck,
  input  wire logic [`IPS_SRC_W-1:0]     excAckSource,
  output logic                           irqPending,
  output logic [`IPS_SRC_W-1:0]          irqSource,
  output logic                           irqLevel,
  input  wire logic                      awvalid,
  output logic                           awready,
  input  wire logic [`IPS_ADDR_W-1:0]    awaddr,
  input  wire logic                      wvalid,
  output logic                           wready,
  input  wire logic [`IPS_DATA_W-1:0]    wdata,
  input  wire logic [3:0]                wstrb,
  output logic                           bvalid,
  input  wire logic                      bready,
  output logic [1:0]                     bresp,
  input  wire logic                      arvalid,
  output logic                           arready,
  input  wire logic [`IPS_ADDR_W-1:0]    araddr,
  output logic                           rvalid,
  input  wire logic                      rready,
  output logic [`IPS_DATA_W-1:0]         rdata,
  output logic [1:0]                     rresp
);
  ips_pkg::ips_top_state_type st;
  ips_pkg::ips_top_state_type stNext;
  ips_pkg::ips_sel_state_type sel;
  ips_flag_if                 fl ();

  logic                     doWrite;
  logic                     arTake;
  logic [`IPS_NUM_SRC-1:0]  levelVec;
  logic [`IPS_NUM_SRC-1:0]  pendVec;
  logic [7:0]               flagByte;
  logic [7:0]               statusByte;

  // ----------------------------------------------------------------------
  // Bus handshakes
  // ----------------------------------------------------------------------
  // One write in flight: new address or data wait until the answer goes
  assign awready = !st.awHeld && !st.bValid;
  assign wready  = !st.wHeld && !st.bValid;
  assign doWrite = st.awHeld && st.wHeld && !st.bValid;
  assign bvalid  = st.bValid;
  assign bresp   = st.bResp;
  assign arready = (st.rdState == ips_pkg::IPS_RD_IDLE);
  assign arTake  = arvalid && arready;
  assign rvalid  = (st.rdState == ips_pkg::IPS_RD_RESP);
  assign rdata   = st.rData;
  assign rresp   = st.rResp;

  // ----------------------------------------------------------------------
  // Priority level per source
  // ----------------------------------------------------------------------
  // Source index follows the default order: smaller index, smaller vector
  always_comb begin
    levelVec     = '0;
    levelVec[0]  = st.prioA[`IPS_PA_LINE0];
    levelVec[1]  = st.prioA[`IPS_PA_LINE1];
    levelVec[2]  = st.prioA[`IPS_PA_LINE23];
    levelVec[3]  = st.prioA[`IPS_PA_LINE23];
    levelVec[4]  = st.prioA[`IPS_PA_LINE45];
    levelVec[5]  = st.prioA[`IPS_PA_LINE45];
    levelVec[6]  = st.prioA[`IPS_PA_WDT];
    levelVec[7]  = st.prioA[`IPS_PA_WDT];
    levelVec[8]  = st.prioA[`IPS_PA_TIMER0];
    levelVec[9]  = st.prioA[`IPS_PA_TIMER1];
    levelVec[10] = st.prioA[`IPS_PA_TIMER2];
    levelVec[11] = st.prioB[`IPS_PB_TIMER3];
    levelVec[12] = st.prioB[`IPS_PB_TIMER4];
    levelVec[13] = st.prioB[`IPS_PB_DMA];
    levelVec[14] = st.prioB[`IPS_PB_DMA];
    levelVec[15] = st.prioB[`IPS_PB_SERIAL0];
    levelVec[16] = st.prioB[`IPS_PB_SERIAL1];
    levelVec[17] = st.prioB[`IPS_PB_ADC];
    // Priority B bits 4 and 0 feed nothing here
  end

  assign pendVec = {intRequest, fl.flags};

  // ----------------------------------------------------------------------
  // Flag unit link
  // ----------------------------------------------------------------------
  assign fl.senseSel = st.sense;
  assign fl.wrData   = st.wData[`IPS_NUM_LINES-1:0];
  assign fl.wrStrobe = doWrite && st.wLane0
                       && (st.awAddr == `IPS_ADDR_FLAGS);
  assign fl.rdStrobe = arTake && (araddr == `IPS_ADDR_FLAGS);
  assign fl.standby  = hwStandby;

  genvar g;
  generate
    for (g = 0; g < `IPS_NUM_LINES; g++) begin : gAck
      assign fl.ackHit[g] = excAck
                            && (excAckSource == `IPS_SRC_W'(g));
    end
  endgenerate

  assign flagByte   = {2'b00, fl.flags};
  assign statusByte = {1'b0, irqPending, irqLevel, irqSource};

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    stNext = st;
    if (awvalid && awready) begin
      stNext.awHeld = 1'b1;
      stNext.awAddr = awaddr;
    end
    if (wvalid && wready) begin
      stNext.wHeld  = 1'b1;
      stNext.wData  = wdata[7:0];
      stNext.wLane0 = wstrb[0];
    end
    if (st.bValid && bready) begin
      stNext.bValid = 1'b0;
    end
    if (doWrite) begin
      stNext.awHeld = 1'b0;
      stNext.wHeld  = 1'b0;
      stNext.bValid = 1'b1;
      stNext.bResp  = `IPS_RESP_OKAY;
      // Writes without lane 0 are answered but change nothing
      if (st.awAddr == `IPS_ADDR_PRIO_A) begin
        if (st.wLane0) begin
          stNext.prioA = st.wData;
        end
      end else if (st.awAddr == `IPS_ADDR_PRIO_B) begin
        if (st.wLane0) begin
          stNext.prioB = st.wData;
        end
      end else if (st.awAddr == `IPS_ADDR_SENSE) begin
        if (st.wLane0) begin
          stNext.sense = st.wData[`IPS_NUM_LINES-1:0];
        end
      end else if (st.awAddr == `IPS_ADDR_FLAGS) begin
        stNext.bResp = `IPS_RESP_OKAY;
      end else if (st.awAddr == `IPS_ADDR_STATUS) begin
        stNext.bResp = `IPS_RESP_OKAY;
      end else begin
        stNext.bResp = `IPS_RESP_SLVERR;
      end
    end
    case (st.rdState)
      ips_pkg::IPS_RD_IDLE: begin
        if (arTake) begin
          stNext.rdState = ips_pkg::IPS_RD_RESP;
          stNext.rData   = '0;
          stNext.rResp   = `IPS_RESP_OKAY;
          if (araddr == `IPS_ADDR_PRIO_A) begin
            stNext.rData[7:0] = st.prioA;
          end else if (araddr == `IPS_ADDR_PRIO_B) begin
            stNext.rData[7:0] = st.prioB;
          end else if (araddr == `IPS_ADDR_FLAGS) begin
            stNext.rData[7:0] = flagByte;
          end else if (araddr == `IPS_ADDR_SENSE) begin
            stNext.rData[`IPS_NUM_LINES-1:0] = st.sense;
          end else if (araddr == `IPS_ADDR_STATUS) begin
            stNext.rData[7:0] = statusByte;
          end else begin
            stNext.rResp = `IPS_RESP_SLVERR;
          end
        end
      end
      ips_pkg::IPS_RD_RESP: begin
        if (rready) begin
          stNext.rdState = ips_pkg::IPS_RD_IDLE;
        end
      end
      default: begin
        stNext.rdState = ips_pkg::IPS_RD_IDLE;
      end
    endcase
    // Standby holds all control registers at their reset value
    if (hwStandby) begin
      stNext.prioA = `IPS_RST_BYTE;
      stNext.prioB = `IPS_RST_BYTE;
      stNext.sense = `IPS_RST_LINES;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st.awHeld  <= 1'b0;
      st.awAddr  <= '0;
      st.wHeld   <= 1'b0;
      st.wData   <= `IPS_RST_BYTE;
      st.wLane0  <= 1'b0;
      st.bValid  <= 1'b0;
      st.bResp   <= `IPS_RESP_OKAY;
      st.rdState <= ips_pkg::IPS_RD_IDLE;
      st.rData   <= '0;
      st.rResp   <= `IPS_RESP_OKAY;
      st.prioA   <= `IPS_RST_BYTE;
      st.prioB   <= `IPS_RST_BYTE;
      st.sense   <= `IPS_RST_LINES;
    end else begin
      st <= stNext;
    end
  end

  // ----------------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------------
  ips_flag_unit uFlags (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .lineN   (externalRequestLineN),
    .fl      (fl.unit)
  );

  ips_prio_sel #(
    .NUM_SRC (`IPS_NUM_SRC),
    .SRC_W   (`IPS_SRC_W)
  ) uSel (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pending (pendVec),
    .level   (levelVec),
    .sel     (sel)
  );

  assign irqPending = sel.valid;
  assign irqSource  = sel.src;
  assign irqLevel   = sel.level;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_PRIO_A_CLEAR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    hwStandby |=> (st.prioA == `IPS_RST_BYTE))
    else $error("priority A not cleared in standby");
  AST_PRIO_B_CLEAR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    hwStandby |=> (st.prioB == `IPS_RST_BYTE))
    else $error("priority B not cleared in standby");
  AST_LINE0_LEVEL: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (irqPending && irqSource == `IPS_SRC_W'(0))
      |-> (irqLevel == $past(st.prioA[`IPS_PA_LINE0])))
    else $error("line 0 level does not follow its priority bit");
  AST_LINE3_LEVEL: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (irqPending && irqSource == `IPS_SRC_W'(3))
      |-> (irqLevel == $past(st.prioA[`IPS_PA_LINE23])))
    else $error("line 3 level does not follow shared bit");
  AST_DMA1_LEVEL: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (irqPending && irqSource == `IPS_SRC_W'(14))
      |-> (irqLevel == $past(st.prioB[`IPS_PB_DMA])))
    else $error("second DMA channel level does not follow shared bit");
  AST_ADC_LEVEL: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (irqPending && irqSource == `IPS_SRC_W'(17))
      |-> (irqLevel == $past(st.prioB[`IPS_PB_ADC])))
    else $error("converter level does not follow its bit");
  AST_RESERVED_B: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ($changed(st.prioB) && (st.prioB[7:5] == $past(st.prioB[7:5]))
      && (st.prioB[3:1] == $past(st.prioB[3:1])) && $stable(st.prioA))
      |-> $stable(levelVec))
    else $error("reserved priority bit changed a level");
  AST_FLAGS_TOP_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (rvalid && $past(arTake) && $past(araddr) == `IPS_ADDR_FLAGS)
      |-> (rdata[7:6] == 2'b00))
    else $error("flag register top bits not zero");
  AST_PRIO_A_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (doWrite && st.wLane0 && !hwStandby
      && st.awAddr == `IPS_ADDR_PRIO_A)
      |=> (st.prioA == $past(st.wData)) ##0 bvalid)
    else $error("priority A write not stored");

  AST_PRIO_B_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (doWrite && st.wLane0 && !hwStandby
      && st.awAddr == `IPS_ADDR_PRIO_B)
      |=> (st.prioB == $past(st.wData)))
    else $error("priority B write not stored");

  AST_LEVEL_PENDING: assert property (@(posedge clk_sys) disable iff (!rst_n)
    irqLevel |-> irqPending)
    else $error("level without request");

  AST_NONE_PENDING: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(|pendVec) |=> !irqPending)
    else $error("request without source");

  AST_SENSE_CLEAR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    hwStandby |=> (st.sense == `IPS_RST_LINES))
    else $error("sense not cleared in standby");

  // Every source, shared bits included, shows its own level
  generate
    for (g = 0; g < `IPS_NUM_SRC; g++) begin : gLvl
      AST_SRC_LEVEL: assert property (@(posedge clk_sys)
        disable iff (!rst_n) (irqPending
          && irqSource == `IPS_SRC_W'(g))
          |-> (irqLevel == $past(levelVec[g])))
        else $error("source level does not follow its bit");
    end
  endgenerate

  // Answers come one edge after the request is complete
  AST_WR_ANSWER: assert property (@(posedge clk_sys) disable iff (!rst_n)
    doWrite |=> (bvalid && !awready && !wready))
    else $error("write answer missing");

  AST_RD_ANSWER: assert property (@(posedge clk_sys) disable iff (!rst_n)
    arTake |=> (rvalid && !arready && rdata[31:8] == '0))
    else $error("read answer missing");

  AST_UNMAPPED_RD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (arTake && araddr > `IPS_ADDR_STATUS) |=> (rresp == `IPS_RESP_SLVERR))
    else $error("unmapped read not refused");
endmodule // ips_top

/* File: design/ips_map.svh */
// Register map, field positions and sizes of the interrupt priority block
`ifndef IPS_MAP_SVH
`define IPS_MAP_SVH

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define IPS_ADDR_W        8
`define IPS_DATA_W        32
`define IPS_NUM_LINES     6
`define IPS_NUM_INT       12
`define IPS_NUM_SRC       18
`define IPS_SRC_W         5

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define IPS_ADDR_PRIO_A   8'h00
`define IPS_ADDR_PRIO_B   8'h04
`define IPS_ADDR_FLAGS    8'h08
`define IPS_ADDR_SENSE    8'h0C
`define IPS_ADDR_STATUS   8'h10

// ----------------------------------------------------------------------
// Reset values and answers
// ----------------------------------------------------------------------
`define IPS_RST_BYTE      8'h00
`define IPS_RST_LINES     6'h00
`define IPS_PIN_IDLE      6'h3F
`define IPS_RESP_OKAY     2'b00
`define IPS_RESP_SLVERR   2'b10

// ----------------------------------------------------------------------
// Priority bit positions
// ----------------------------------------------------------------------
`define IPS_PA_LINE0      7
`define IPS_PA_LINE1      6
`define IPS_PA_LINE23     5
`define IPS_PA_LINE45     4
`define IPS_PA_WDT        3
`define IPS_PA_TIMER0     2
`define IPS_PA_TIMER1     1
`define IPS_PA_TIMER2     0
`define IPS_PB_TIMER3     7
`define IPS_PB_TIMER4     6
`define IPS_PB_DMA        5
`define IPS_PB_SERIAL0    3
`define IPS_PB_SERIAL1    2
`define IPS_PB_ADC        1

`endif

/* File: design/ips_pkg.sv */
// Types shared by the interrupt priority block
package ips_pkg;
  `include "ips_map.svh"

  typedef enum logic [0:0] {
    IPS_RD_IDLE = 1'b0,
    IPS_RD_RESP = 1'b1
  } ips_rd_state_type;

  typedef struct packed {
    logic [`IPS_NUM_LINES-1:0] sync1;
    logic [`IPS_NUM_LINES-1:0] sync2;
    logic [`IPS_NUM_LINES-1:0] prev;
    logic [`IPS_NUM_LINES-1:0] flag;
    logic [`IPS_NUM_LINES-1:0] armed;
  } ips_flag_state_type;

  typedef struct packed {
    logic                  valid;
    logic [`IPS_SRC_W-1:0] src;
    logic                  level;
  } ips_sel_state_type;

  typedef struct packed {
    logic                      awHeld;
    logic [`IPS_ADDR_W-1:0]    awAddr;
    logic                      wHeld;
    logic [7:0]                wData;
    logic                      wLane0;
    logic                      bValid;
    logic [1:0]                bResp;
    ips_rd_state_type          rdState;
    logic [`IPS_DATA_W-1:0]    rData;
    logic [1:0]                rResp;
    logic [7:0]                prioA;
    logic [7:0]                prioB;
    logic [`IPS_NUM_LINES-1:0] sense;
  } ips_top_state_type;
endpackage

/* File: design/ips_flag_if.sv */
// Link between the register logic and the request flag unit
`timescale 1ns/1ps
`include "ips_map.svh"
interface ips_flag_if;
  logic [`IPS_NUM_LINES-1:0] senseSel;
  logic [`IPS_NUM_LINES-1:0] wrData;
  logic                      wrStrobe;
  logic                      rdStrobe;
  logic                      standby;
  logic [`IPS_NUM_LINES-1:0] ackHit;
  logic [`IPS_NUM_LINES-1:0] flags;

  modport unit (input senseSel, wrData, wrStrobe, rdStrobe, standby, ackHit,
                output flags);
  modport ctrl (output senseSel, wrData, wrStrobe, rdStrobe, standby, ackHit,
                input flags);
endinterface

/* File: design/ips_flag_unit.sv */
// External request flags: pin synchroniser, sense, set and clear
`timescale 1ns/1ps
`include "ips_map.svh"
module ips_flag_unit (
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  input  wire logic [`IPS_NUM_LINES-1:0] lineN,
  ips_flag_if.unit                       fl
);
  ips_pkg::ips_flag_state_type st;
  ips_pkg::ips_flag_state_type stNext;
  logic [`IPS_NUM_LINES-1:0]   setHit;
  logic [`IPS_NUM_LINES-1:0]   clrHit;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    stNext = st;
    stNext.sync1 = lineN;
    stNext.sync2 = st.sync1;
    stNext.prev  = st.sync2;
    setHit = (~st.sync2 & ~fl.senseSel)
           | (st.prev & ~st.sync2 & fl.senseSel);
    clrHit = fl.ackHit & (fl.senseSel | st.sync2);
    if (fl.wrStrobe) begin
      clrHit = clrHit | (~fl.wrData & st.armed);
    end
    // Set beats a write or acknowledge clear landing in the same cycle; standby beats set
    stNext.flag  = (st.flag & ~clrHit) | setHit;
    stNext.armed = (st.armed | (fl.rdStrobe ? st.flag : `IPS_RST_LINES))
                 & stNext.flag;
    if (fl.standby) begin
      stNext.flag  = `IPS_RST_LINES;
      stNext.armed = `IPS_RST_LINES;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st.sync1 <= `IPS_PIN_IDLE;
      st.sync2 <= `IPS_PIN_IDLE;
      st.prev  <= `IPS_PIN_IDLE;
      st.flag  <= `IPS_RST_LINES;
      st.armed <= `IPS_RST_LINES;
    end else begin
      st <= stNext;
    end
  end

  assign fl.flags = st.flag;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_LEVEL_SET: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!fl.standby && !fl.senseSel[0] && !st.sync2[0]) |=> st.flag[0])
    else $error("level mode low pin did not set flag");
  AST_EDGE_SET: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!fl.standby && fl.senseSel[1] && st.prev[1] && !st.sync2[1])
      |=> st.flag[1])
    else $error("falling edge did not set flag");
  AST_NO_WRITE_SET: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(st.flag[2]) |-> $past(setHit[2]))
    else $error("flag set without a sense event");
  AST_UNARMED_KEEP: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st.flag[3] && !st.armed[3] && fl.wrStrobe && !fl.wrData[3]
      && !fl.ackHit[3] && !fl.standby) |=> st.flag[3])
    else $error("unread flag cleared by write");
  AST_EDGE_ACK_CLR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (fl.ackHit[4] && fl.senseSel[4] && !setHit[4]) |=> !st.flag[4])
    else $error("edge flag not cleared by exception handling");
  AST_STANDBY_CLR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    fl.standby |=> (st.flag == `IPS_RST_LINES))
    else $error("flags not cleared in standby");
endmodule // ips_flag_unit

/* File: design/ips_prio_sel.sv */
// Two-level priority selection over all request sources
`timescale 1ns/1ps
`include "ips_map.svh"
module ips_prio_sel #(
  parameter int NUM_SRC = `IPS_NUM_SRC,
  parameter int SRC_W   = `IPS_SRC_W
) (
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  input  wire logic [NUM_SRC-1:0] pending,
  input  wire logic [NUM_SRC-1:0] level,
  output ips_pkg::ips_sel_state_type sel
);
  ips_pkg::ips_sel_state_type st;
  ips_pkg::ips_sel_state_type stNext;
  logic                       anyHigh;

  // ----------------------------------------------------------------------
  // Selection
  // ----------------------------------------------------------------------
  always_comb begin
    stNext  = st;
    anyHigh = |(pending & level);
    stNext.valid = |pending;
    stNext.level = anyHigh;
    stNext.src   = '0;
    // Scan downward so the smallest qualifying index is kept
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (pending[i] && (level[i] || !anyHigh)) begin
        stNext.src = SRC_W'(i);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= stNext;
    end
  end

  assign sel = st;

  AST_HIGH_FIRST: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (|(pending & level)) |=> (st.valid && st.level
      && |($past(level) & (NUM_SRC'(1) << st.src))))
    else $error("low level request chosen over high level");
  AST_LOW_INDEX: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pending[0] && (level[0] || !(|(pending & level))))
      |=> (st.src == '0))
    else $error("smaller source index not favoured");
endmodule // ips_prio_sel

/* File: testbench/ips_cpu_model.sv */
// Processor and on-chip source model facing the interrupt block
`timescale 1ns/1ps
module ips_cpu_model (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        irqPending,
  input  wire logic [4:0]  irqSource,
  input  wire logic        takeOn,
  input  wire logic [5:0]  pinLow,
  input  wire logic [11:0] reqOn,
  output logic             excAck,
  output logic [4:0]       excAckSource,
  output logic [5:0]       lineN,
  output logic [11:0]      intRequest
);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      excAck       <= 1'b0;
      excAckSource <= 5'h00;
      lineN        <= 6'h3F;
      intRequest   <= 12'h000;
    end else begin
      // One-cycle gap after each take, shorter than the two edges irqPending needs to drop, so a request can be taken twice
      excAck       <= takeOn && irqPending && !excAck;
      excAckSource <= irqSource;
      lineN        <= ~pinLow;
      intRequest   <= reqOn;
    end
  end
endmodule // ips_cpu_model

/* File: testbench/test_irq_priority_and_status.sv */
// Self-checking bench of the interrupt priority and flag block
`timescale 1ns/1ps
module test_irq_priority_and_status;
  logic        clk_sys = 1'b0, rst_n = 1'b0, hwStandby = 1'b0, takeOn = 1'b0;
  logic [5:0]  pinLow = 6'h00, lineN;
  logic [11:0] reqOn = 12'h000, intRequest;
  logic        excAck, irqPending, irqLevel, awready, wready, bvalid;
  logic [4:0]  excAckSource, irqSource;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, arready, rvalid;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rdV;
  logic [1:0]  bresp, rresp, rsp;
  int          num_errors = 0, tests_run = 0;
  always #2 clk_sys = ~clk_sys;
  ips_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .hwStandby(hwStandby),
    .externalRequestLineN(lineN), .intRequest(intRequest), .excAck(excAck),
    .excAckSource(excAckSource), .irqPending(irqPending),
    .irqSource(irqSource), .irqLevel(irqLevel), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
  ips_cpu_model cpu (.clk_sys(clk_sys), .rst_n(rst_n),
    .irqPending(irqPending), .irqSource(irqSource), .takeOn(takeOn),
    .pinLow(pinLow), .reqOn(reqOn), .excAck(excAck),
    .excAckSource(excAckSource), .lineN(lineN), .intRequest(intRequest));
  task automatic chk(input string n, input logic [31:0] e, s);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aW = 1'b1, wW = 1'b1, aT, wT;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aW || wW) begin
      @(negedge clk_sys);
      aT = aW && awready;
      wT = wW && wready;
      @(posedge clk_sys);
      if (aT) awvalid <= 1'b0;
      if (wT) wvalid <= 1'b0;
      aW = aW && !aT;
      wW = wW && !wT;
    end
    do @(negedge clk_sys); while (!bvalid);
    @(posedge clk_sys);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk_sys); while (!arready);
    @(posedge clk_sys);
    arvalid <= 1'b0;
    do @(negedge clk_sys); while (!rvalid);
    rdV = rdata;
    rsp = rresp;
    @(posedge clk_sys);
    rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk("register", e, rdV);
  endtask
  task automatic give_verdict;
    $display("errors %0d, checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Nibble per source: priority bit, plus 8 when in the second register
  task automatic t_prio;
    logic [71:0] map = 72'h9ABDDEF01233445567;
    logic [3:0]  e;
    int          f;
    pinLow <= 6'h3F;
    reqOn <= 12'hFFF;
    for (int s = 0; s < 18; s++) begin
      e = map[4*s +: 4];
      f = s;
      for (int j = s - 1; j >= 0; j--) if (map[4*j +: 4] == e) f = j;
      wr(8'h00, e[3] ? 32'h0 : 32'h1 << e[2:0]);
      wr(8'h04, e[3] ? 32'h1 << e[2:0] : 32'h0);
      repeat (2) @(negedge clk_sys);
      chk("irqSource", f, irqSource);
      chk("irqLevel", 32'h1, irqLevel);
    end
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h11);
    repeat (2) @(negedge clk_sys);
    chk("irqLevel", 32'h0, irqLevel);
    chk("irqSource", 32'h0, irqSource);
    rchk(8'h04, 32'h11);
    rchk(8'h10, 32'h40);
    wr(8'h04, 32'h01);
    rchk(8'h04, 32'h01);
  endtask
  task automatic t_flags;
    pinLow <= 6'h00;
    reqOn <= 12'h000;
    rchk(8'h08, 32'h3F);
    wr(8'h08, 32'hFF);
    rchk(8'h08, 32'h3F);
    wr(8'h08, 32'h0);
    rchk(8'h08, 32'h0);
    wr(8'h0C, 32'h3F);
    rchk(8'h0C, 32'h3F);
    pinLow <= 6'h04;
    repeat (2) @(posedge clk_sys);
    pinLow <= 6'h00;
    repeat (4) @(posedge clk_sys);
    wr(8'h08, 32'h0);
    rchk(8'h08, 32'h04);
    takeOn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    takeOn <= 1'b0;
    rchk(8'h08, 32'h0);
  endtask
  task automatic t_misc;
    rd(8'h20);
    chk("rresp", 32'h2, rsp);
    wr(8'h00, 32'hFF);
    hwStandby <= 1'b1;
    @(posedge clk_sys);
    hwStandby <= 1'b0;
    rchk(8'h00, 32'h0);
    rchk(8'h04, 32'h0);
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    rchk(8'h00, 32'h0);
    rchk(8'h04, 32'h0);
    rchk(8'h08, 32'h0);
    t_prio();
    t_flags();
    t_misc();
    give_verdict();
  end
  initial begin
    #100000;
    num_errors++;
    give_verdict();
  end
endmodule // test_irq_priority_and_status
